//--- eif_pkg.sv
// package for the external request flag and priority block
// assumes a 32-bit avalon-mm slave with word-aligned registers
package eif_pkg;
   // ----------------------------------------
   // register word indices and byte addresses
   // ----------------------------------------
   localparam logic [9:0] PRIO_A_IDX = 10'h0f8;
   localparam logic [9:0] PRIO_B_IDX = 10'h0f9;
   localparam logic [9:0] SENSE_IDX = 10'h0f4;
   localparam logic [9:0] ENABLE_IDX = 10'h0f5;
   localparam logic [9:0] FLAG_IDX = 10'h0f6;
   localparam logic [9:0] IRQ_STATUS_IDX = 10'h100;
   localparam logic [9:0] IRQ_MASK_IDX = 10'h101;
   localparam logic [9:0] PENDING_IDX = 10'h102;
   localparam logic [11:0] PRIO_A_ADDR = {PRIO_A_IDX, 2'b00};
   localparam logic [11:0] PRIO_B_ADDR = {PRIO_B_IDX, 2'b00};
   localparam logic [11:0] SENSE_ADDR = {SENSE_IDX, 2'b00};
   localparam logic [11:0] ENABLE_ADDR = {ENABLE_IDX, 2'b00};
   localparam logic [11:0] FLAG_ADDR = {FLAG_IDX, 2'b00};
   localparam logic [11:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
   localparam logic [11:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
   localparam logic [11:0] PENDING_ADDR = {PENDING_IDX, 2'b00};
   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam logic [7:0] PIN_MASK = 8'h33;
   localparam logic [7:0] PRIO_A_RESET = 8'h00;
   localparam logic [7:0] PRIO_B_RESET = 8'h00;
   localparam logic [7:0] PRIO_B_MASK = 8'hce;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int PRIO_A_PIN0 = 7;
   localparam int PRIO_A_PIN1 = 6;
   localparam int PRIO_A_PIN45 = 4;
   localparam int PRIO_A_WDOG = 3;
   localparam int PRIO_B_TMR3 = 7;
   localparam int PRIO_B_SER0 = 3;
   localparam int PRIO_B_ADC = 1;
   localparam int NUM_SRC = 14;
   // source numbering of the request vector
   localparam int SRC_PIN0 = 0;
   localparam int SRC_PIN1 = 1;
   localparam int SRC_PIN4 = 2;
   localparam int SRC_PIN5 = 3;
   localparam int SRC_WDOG = 4;
   localparam int SRC_TMR0 = 5;
   localparam int SRC_SER0 = 10;
   localparam int SRC_ADC = 12;
   localparam logic [3:0] NO_SRC = 4'hf;
   // bus answer states
   typedef enum logic [0:0] {
      EIF_IDLE = 1'b0,
      EIF_DONE = 1'b1
   } eif_bus_type;
endpackage

//--- eif_pin_sense.sv
// one external request pin: synchroniser, sense logic and flag
// assumes the pin is asynchronous to clk_in
`timescale 1ns/1ns
`default_nettype none
module eif_pin_sense (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic pin_n_in,
   input wire logic sense_edge_in,
   input wire logic armed_read_in,
   input wire logic write_zero_in,
   input wire logic exc_ack_in,
   output logic flag_out
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic set_now;
   logic clr_now;

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         prev_q <= 1'b1;
      end else if (enable_in) begin
         sync1_q <= pin_n_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // ----------------------------------------
   // flag
   // ----------------------------------------
   always_comb begin
      // level mode: set while low edge mode: set on fall
      set_now = sense_edge_in ? (prev_q & ~sync2_q) : ~sync2_q;
      // read-one-then-write-zero clear
      clr_now = armed_read_in & write_zero_in;
      // exception handling clear: level mode only when pin high
      if (exc_ack_in && (sense_edge_in || sync2_q)) begin
         clr_now = 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         flag_out <= 1'b0;
      end else if (enable_in) begin
         // a set in the clearing cycle wins
         if (set_now) begin
            flag_out <= 1'b1;
         end else if (clr_now) begin
            flag_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- eif_ctrl.sv
// external request flags, per-pin sense and enable, source priority
// assumes avalon-mm master on clk_in; pins asynchronous; peripherals on clk_in
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module eif_ctrl
   import eif_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic [11:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [3:0] request_pin_n_in,
   input wire logic watchdog_req_in,
   input wire logic [4:0] timer_req_in,
   input wire logic [1:0] serial_req_in,
   input wire logic adc_req_in,
   input wire logic exc_ack_in,
   input wire logic [3:0] exc_src_in,
   output logic cpu_req_out,
   output logic [3:0] cpu_src_out,
   output logic cpu_level_out,
   output logic irq_out
);
   eif_bus_type state_q;
   logic [7:0] prio_a_q;
   logic [7:0] prio_b_q;
   logic [7:0] sense_q;
   logic [7:0] enable_q;
   logic [7:0] armed_q;
   logic [7:0] irq_status_q;
   logic [7:0] irq_mask_q;
   logic [3:0] flag;
   logic [7:0] flag_reg;
   logic [NUM_SRC-1:0] req;
   logic [NUM_SRC-1:0] lvl;
   logic [7:0] events;
   logic [3:0] pick_src;
   logic pick_lvl;
   logic pick_any;
   logic [7:0] rd_mux;
   logic wr_hit;
   logic rd_hit;
   logic wr_lane0;
   logic flag_wr;
   logic flag_rd;
   logic wr_prio_a;
   logic wr_prio_b;
   logic wr_sense;
   logic wr_enable;
   logic wr_mask;

   // ----------------------------------------
   // register bus: one wait cycle, then answer
   // ----------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   assign wr_hit = avs_write_in && (state_q == EIF_IDLE);
   assign rd_hit = avs_read_in && (state_q == EIF_IDLE);
   assign wr_lane0 = wr_hit && avs_byteenable_in[0];
   assign flag_wr = wr_lane0 && hit(avs_address_in, FLAG_ADDR);
   assign flag_rd = rd_hit && hit(avs_address_in, FLAG_ADDR);

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= EIF_IDLE;
      end else if (enable_in) begin
         case (state_q)
            EIF_IDLE: begin
               if (avs_read_in || avs_write_in) begin
                  state_q <= EIF_DONE;
               end
            end
            EIF_DONE: begin
               state_q <= EIF_IDLE;
            end
            default: begin
               state_q <= EIF_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         avs_waitrequest_out <= 1'b1;
      end else if (enable_in) begin
         // low for exactly the cycle after the request is taken
         avs_waitrequest_out <= ~(rd_hit || wr_hit);
      end
   end

   // ----------------------------------------
   // writable registers
   // ----------------------------------------
   // one decode, so a single bus write can only ever reach one register
   always_comb begin
      wr_prio_a = 1'b0;
      wr_prio_b = 1'b0;
      wr_sense = 1'b0;
      wr_enable = 1'b0;
      wr_mask = 1'b0;
      if (wr_lane0) begin
         if (hit(avs_address_in, PRIO_A_ADDR)) begin
            wr_prio_a = 1'b1;
         end else if (hit(avs_address_in, PRIO_B_ADDR)) begin
            wr_prio_b = 1'b1;
         end else if (hit(avs_address_in, SENSE_ADDR)) begin
            wr_sense = 1'b1;
         end else if (hit(avs_address_in, ENABLE_ADDR)) begin
            wr_enable = 1'b1;
         end else if (hit(avs_address_in, IRQ_MASK_ADDR)) begin
            wr_mask = 1'b1;
         end
      end
   end

   // all eight bits stored, bit 5 included
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         prio_a_q <= PRIO_A_RESET;
      end else if (enable_in && wr_prio_a) begin
         prio_a_q <= avs_writedata_in[7:0];
      end
   end

   // unused bits 5, 4, 0 read as zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         prio_b_q <= PRIO_B_RESET;
      end else if (enable_in && wr_prio_b) begin
         prio_b_q <= avs_writedata_in[7:0] & PRIO_B_MASK;
      end
   end

   // sense select, one bit per pin
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sense_q <= REG_RESET;
      end else if (enable_in && wr_sense) begin
         sense_q <= avs_writedata_in[7:0];
      end
   end

   // enables start closed, so no pin reaches the cpu until software opens it
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         enable_q <= REG_RESET;
      end else if (enable_in && wr_enable) begin
         enable_q <= avs_writedata_in[7:0];
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_mask_q <= REG_RESET;
      end else if (enable_in && wr_mask) begin
         irq_mask_q <= avs_writedata_in[7:0];
      end
   end

   // ----------------------------------------
   // pin flags
   // ----------------------------------------
   // a flag bit is armed by a read that saw it at one; any write to the flag register with byte lane 0 enabled disarms
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         armed_q <= REG_RESET;
      end else if (enable_in) begin
         if (flag_rd) begin
            armed_q <= flag_reg;
         end else if (flag_wr) begin
            armed_q <= REG_RESET;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         localparam int BIT = (gi < 2) ? gi : gi + 2;
         eif_pin_sense u_pin (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .enable_in(enable_in),
            .pin_n_in(request_pin_n_in[gi]),
            .sense_edge_in(sense_q[BIT]),
            .armed_read_in(armed_q[BIT]),
            // only a written zero clears; a one is ignored
            .write_zero_in(flag_wr && !avs_writedata_in[BIT]),
            .exc_ack_in(exc_ack_in && (exc_src_in == 4'(gi))),
            .flag_out(flag[gi])
         );
      end
   endgenerate

   assign flag_reg = {2'b00, flag[3], flag[2], 2'b00, flag[1], flag[0]};

   // ----------------------------------------
   // source requests and levels
   // ----------------------------------------
   always_comb begin
      // pin requests need flag and enable
      req = '0;
      req[SRC_PIN0] = flag[0] & enable_q[0];
      req[SRC_PIN1] = flag[1] & enable_q[1];
      req[SRC_PIN4] = flag[2] & enable_q[4];
      req[SRC_PIN5] = flag[3] & enable_q[5];
      req[SRC_WDOG] = watchdog_req_in;
      req[SRC_TMR0 +: 5] = timer_req_in;
      req[SRC_SER0 +: 2] = serial_req_in;
      req[SRC_ADC] = adc_req_in;
      // source to priority bit mapping
      lvl = '0;
      lvl[SRC_PIN0] = prio_a_q[PRIO_A_PIN0];
      lvl[SRC_PIN1] = prio_a_q[PRIO_A_PIN1];
      lvl[SRC_PIN4] = prio_a_q[PRIO_A_PIN45];
      lvl[SRC_PIN5] = prio_a_q[PRIO_A_PIN45];
      lvl[SRC_WDOG] = prio_a_q[PRIO_A_WDOG];
      lvl[SRC_TMR0] = prio_a_q[2];
      lvl[SRC_TMR0+1] = prio_a_q[1];
      lvl[SRC_TMR0+2] = prio_a_q[0];
      lvl[SRC_TMR0+3] = prio_b_q[PRIO_B_TMR3];
      lvl[SRC_TMR0+4] = prio_b_q[PRIO_B_TMR3-1];
      lvl[SRC_SER0] = prio_b_q[PRIO_B_SER0];
      lvl[SRC_SER0+1] = prio_b_q[PRIO_B_SER0-1];
      lvl[SRC_ADC] = prio_b_q[PRIO_B_ADC];
   end

   // level 1 first, then lowest source number
   always_comb begin
      pick_src = NO_SRC;
      pick_lvl = 1'b0;
      pick_any = 1'b0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i] && !lvl[i] && !pick_any) begin
            pick_src = 4'(i);
         end
      end
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i] && lvl[i]) begin
            pick_src = 4'(i);
            pick_lvl = 1'b1;
         end
      end
      pick_any = |req;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cpu_req_out <= 1'b0;
         cpu_src_out <= NO_SRC;
         cpu_level_out <= 1'b0;
      end else if (enable_in) begin
         cpu_req_out <= pick_any;
         cpu_src_out <= pick_any ? pick_src : NO_SRC;
         cpu_level_out <= pick_lvl;
      end
   end

   // ----------------------------------------
   // status, mask and interrupt line
   // ----------------------------------------
   // a pin flag rising counts as an event; a read clears, an event wins
   logic [3:0] flag_prev_q;
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         flag_prev_q <= 4'h0;
      end else if (enable_in) begin
         flag_prev_q <= flag;
      end
   end
   assign events = {4'h0, flag & ~flag_prev_q};

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_status_q <= REG_RESET;
      end else if (enable_in) begin
         if (rd_hit && hit(avs_address_in, IRQ_STATUS_ADDR)) begin
            irq_status_q <= events;
         end else begin
            irq_status_q <= irq_status_q | events;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         irq_out <= 1'b0;
      end else if (enable_in) begin
         irq_out <= |((irq_status_q | events) & irq_mask_q);
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb begin
      if (hit(avs_address_in, PRIO_A_ADDR)) begin
         rd_mux = prio_a_q;
      end else if (hit(avs_address_in, PRIO_B_ADDR)) begin
         rd_mux = prio_b_q;
      end else if (hit(avs_address_in, SENSE_ADDR)) begin
         rd_mux = sense_q;
      end else if (hit(avs_address_in, ENABLE_ADDR)) begin
         rd_mux = enable_q;
      end else if (hit(avs_address_in, FLAG_ADDR)) begin
         rd_mux = flag_reg;
      end else if (hit(avs_address_in, IRQ_STATUS_ADDR)) begin
         rd_mux = irq_status_q;
      end else if (hit(avs_address_in, IRQ_MASK_ADDR)) begin
         rd_mux = irq_mask_q;
      end else if (hit(avs_address_in, PENDING_ADDR)) begin
         rd_mux = {3'b000, pick_lvl, pick_src};
      end else begin
         // unmapped reads answer zero
         rd_mux = 8'h00;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         avs_readdata_out <= 32'h00000000;
      end else if (enable_in && rd_hit) begin
         avs_readdata_out <= {24'h000000, rd_mux};
      end
   end
endmodule
`default_nettype wire

//--- eif_ctrl_monitor.sv
// port-level checker for eif_ctrl
// assumes one clock domain and bind from the bench top
`timescale 1ns/1ns
`default_nettype none
module eif_ctrl_monitor
   import eif_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic [11:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic watchdog_req_in,
   input wire logic [4:0] timer_req_in,
   input wire logic [1:0] serial_req_in,
   input wire logic adc_req_in,
   input wire logic cpu_req_out,
   input wire logic [3:0] cpu_src_out,
   input wire logic cpu_level_out
);
   // ----
   // properties
   // ----
   wire logic [8:0] per_w = {adc_req_in, serial_req_in, timer_req_in, watchdog_req_in};
   wire logic rq_w = avs_read_in | avs_write_in;
   wire logic done_w = avs_read_in & ~avs_waitrequest_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   chk_bus_answer: assert property (rq_w && avs_waitrequest_out && enable_in |=>
      !avs_waitrequest_out) else $error("bus answer late");
   chk_answer_single: assert property (!avs_waitrequest_out && enable_in |=>
      avs_waitrequest_out) else $error("answer longer than one cycle");
   chk_no_spurious: assert property (!rq_w && avs_waitrequest_out |=>
      avs_waitrequest_out) else $error("answer without request");
   chk_unmapped_zero: assert property (done_w && avs_address_in == 12'h010 |->
      avs_readdata_out == 32'h0) else $error("unmapped read not zero");
   chk_prio_b_spare: assert property (done_w && avs_address_in == PRIO_B_ADDR |->
      (avs_readdata_out & ~{24'h0, PRIO_B_MASK}) == 32'h0) else $error("spare bits set");
   chk_src_valid: assert property (cpu_req_out |-> cpu_src_out <= 4'hc)
      else $error("bad source number");
   chk_idle_quiet: assert property (!cpu_req_out |->
      cpu_src_out == NO_SRC && !cpu_level_out) else $error("idle outputs wrong");
   chk_per_forward: assert property (enable_in && per_w != 9'h0 |=> cpu_req_out)
      else $error("peripheral request lost");
   chk_per_cause: assert property (cpu_req_out && cpu_src_out >= 4'h4 &&
      $past(enable_in) |-> (($past(per_w) >> (cpu_src_out - 4'h4)) & 9'h1) != 9'h0)
      else $error("peripheral chosen without request");
endmodule
`default_nettype wire

//--- eif_cpu_model.sv
// cpu core model: takes the forwarded request as an exception
// assumes the bench opens ack_en_in only where it wants handling
`timescale 1ns/1ns
`default_nettype none
module eif_cpu_model (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ack_en_in,
   input wire logic cpu_req_in,
   input wire logic [3:0] cpu_src_in,
   output logic exc_ack_out,
   output logic [3:0] exc_src_out
);
   // ----
   // exception take
   // ----
   // one pulse then a gap, since the request drops a cycle after the clear
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         exc_ack_out <= 1'b0;
         exc_src_out <= 4'hf;
      end else begin
         exc_ack_out <= ack_en_in & cpu_req_in & ~exc_ack_out;
         exc_src_out <= cpu_src_in;
      end
   end
endmodule
`default_nettype wire

//--- eif_ctrl_bench.sv
// self-checking bench for eif_ctrl over avalon-mm
// assumes the cpu model and the checker bound below
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   $display("unexpected %s expected %h seen %h", nm, e, g); err_total++; end end
module eif_ctrl_bench;
   import eif_pkg::*;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic ack_en = 1'b0;
   logic en = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [11:0] adr = 12'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'h0;
   logic [3:0] pin_n = 4'hf;
   logic wdg = 1'b0;
   logic [4:0] tmr = 5'h0;
   logic [1:0] ser = 2'h0;
   logic adc = 1'b0;
   logic [7:0] d;
   logic [7:0] pa [9] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] pb [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h40, 8'h08, 8'h04, 8'h02};
   wire logic [31:0] rdat;
   wire logic wreq, eack, creq, clvl, irq;
   wire logic [3:0] esrc, csrc;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   always #5 clk_in = ~clk_in;
   eif_ctrl dut_u (.clk_in(clk_in), .reset_in(reset_in), .enable_in(en),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
      .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
      .request_pin_n_in(pin_n), .watchdog_req_in(wdg), .timer_req_in(tmr),
      .serial_req_in(ser), .adc_req_in(adc), .exc_ack_in(eack), .exc_src_in(esrc),
      .cpu_req_out(creq), .cpu_src_out(csrc), .cpu_level_out(clvl), .irq_out(irq));
   eif_cpu_model cpu_u (.clk_in(clk_in), .reset_in(reset_in), .ack_en_in(ack_en),
      .cpu_req_in(creq), .cpu_src_in(csrc), .exc_ack_out(eack), .exc_src_out(esrc));
   // ----
   // bus tasks
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] v,
      input logic [3:0] b);
      @(posedge clk_in);
      adr <= a;
      wdat <= {24'h0, v};
      be <= b;
      rd <= ~w;
      wr <= w;
      do @(posedge clk_in); while (wreq !== 1'b0);
      d = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wr8(input logic [11:0] a, input logic [7:0] v);
      acc(1'b1, a, v, 4'h1);
   endtask
   task automatic rc(input logic [11:0] a, input logic [7:0] e, input string nm);
      acc(1'b0, a, 8'h00, 4'hf);
      `CHK(nm, e, d)
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         report_and_stop();
      end
   end
   // ----
   // tests
   // ----
   initial begin
      tick(20);
      reset_in <= 1'b0;
      rc(PRIO_A_ADDR, PRIO_A_RESET, "prio_a");
      rc(PRIO_B_ADDR, PRIO_B_RESET, "prio_b");
      rc(SENSE_ADDR, REG_RESET, "sense");
      rc(ENABLE_ADDR, REG_RESET, "enable");
      rc(FLAG_ADDR, REG_RESET, "flag");
      wr8(PRIO_A_ADDR, 8'hff);
      rc(PRIO_A_ADDR, 8'hff, "prio_a_rw");
      acc(1'b1, PRIO_A_ADDR, 8'h00, 4'h0);
      rc(PRIO_A_ADDR, 8'hff, "prio_a_nolane");
      wr8(PRIO_B_ADDR, 8'hff);
      rc(PRIO_B_ADDR, PRIO_B_MASK, "prio_b_rw");
      wr8(12'h010, 8'h5a);
      rc(12'h010, 8'h00, "unmapped");
      wr8(PRIO_A_ADDR, 8'h00);
      wr8(PRIO_B_ADDR, 8'h00);
      wr8(SENSE_ADDR, 8'h12);
      pin_n <= 4'b1110;
      tick(6);
      rc(FLAG_ADDR, 8'h01, "flag_level");
      `CHK("req_blocked", 1'b0, creq)
      rc(IRQ_STATUS_ADDR, 8'h01, "status");
      rc(IRQ_STATUS_ADDR, 8'h00, "status_clr");
      pin_n <= 4'b1111;
      tick(6);
      // the write of one disarms, so the zero that follows must not clear
      wr8(FLAG_ADDR, 8'h01);
      wr8(FLAG_ADDR, 8'h00);
      rc(FLAG_ADDR, 8'h01, "flag_unarmed");
      wr8(FLAG_ADDR, 8'h00);
      rc(FLAG_ADDR, 8'h00, "flag_armed");
      wr8(FLAG_ADDR, 8'h33);
      rc(FLAG_ADDR, 8'h00, "flag_one");
      pin_n <= 4'b1101;
      tick(6);
      rc(FLAG_ADDR, 8'h02, "flag_edge");
      wr8(FLAG_ADDR, 8'h00);
      rc(FLAG_ADDR, 8'h00, "flag_edge_low");
      pin_n <= 4'b1111;
      wr8(ENABLE_ADDR, 8'h33);
      pin_n <= 4'b1011;
      tick(6);
      `CHK("src_pin4", 4'h2, csrc)
      ack_en <= 1'b1;
      tick(4);
      ack_en <= 1'b0;
      rc(FLAG_ADDR, 8'h00, "flag_exc_edge");
      pin_n <= 4'b0011;
      tick(6);
      `CHK("src_pin5", 4'h3, csrc)
      pin_n <= 4'b1111;
      tick(6);
      rc(FLAG_ADDR, 8'h20, "flag_held");
      ack_en <= 1'b1;
      tick(4);
      ack_en <= 1'b0;
      rc(FLAG_ADDR, 8'h00, "flag_exc_level");
      acc(1'b0, IRQ_STATUS_ADDR, 8'h00, 4'hf);
      pin_n <= 4'b1110;
      tick(6);
      `CHK("irq_masked", 1'b0, irq)
      wr8(IRQ_MASK_ADDR, 8'h01);
      tick(2);
      `CHK("irq_set", 1'b1, irq)
      rc(IRQ_STATUS_ADDR, 8'h01, "status_pin0");
      tick(2);
      `CHK("irq_clr", 1'b0, irq)
      wdg <= 1'b1;
      tick(3);
      `CHK("tie_src", 4'h0, csrc)
      `CHK("tie_lvl", 1'b0, clvl)
      // pin0 stays pending at level 0, so each source must win on level alone
      for (int i = 0; i < 9; i++) begin
         wr8(PRIO_A_ADDR, pa[i]);
         wr8(PRIO_B_ADDR, pb[i]);
         {adc, ser, tmr, wdg} <= 9'(1 << i);
         tick(3);
         `CHK("prio_src", 4'(4 + i), csrc)
         `CHK("prio_lvl", 1'b1, clvl)
      end
      rc(PENDING_ADDR, {3'b000, 1'b1, 4'(SRC_ADC)}, "pending");
      // a frozen block must hold its outputs while the requests change
      en <= 1'b0;
      {adc, ser, tmr, wdg} <= 9'h000;
      tick(4);
      `CHK("frozen_src", 4'(SRC_ADC), csrc)
      en <= 1'b1;
      tick(3);
      `CHK("thawed_src", 4'(SRC_PIN0), csrc)
      report_and_stop();
   end
endmodule
bind eif_ctrl eif_ctrl_monitor mon_u (.clk_in(clk_in), .reset_in(reset_in),
   .enable_in(enable_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .watchdog_req_in(watchdog_req_in),
   .timer_req_in(timer_req_in), .serial_req_in(serial_req_in), .adc_req_in(adc_req_in),
   .cpu_req_out(cpu_req_out), .cpu_src_out(cpu_src_out), .cpu_level_out(cpu_level_out));
`default_nettype wire
